// ### src/fp_exc_defs.vh
// Constants for the floating-point invalid-operation exception unit
`ifndef FP_EXC_DEFS_VH
`define FP_EXC_DEFS_VH

// Mode encodings {fp_exc_mode_hi, fp_exc_mode_lo}
`define MODE_IGNORE 2'h0
`define MODE_IMP_NONREC 2'h1
`define MODE_IMP_REC 2'h2
`define MODE_PRECISE 2'h3

// Operation classes presented by the pipeline
`define OP_ARITH 3'h0
`define OP_ROUND_SINGLE 3'h1
`define OP_CMP_ORDERED 3'h2
`define OP_CVT64 3'h3
`define OP_CVT32 3'h4
`define OP_MOVE 3'h5
`define OP_CMP_UNORDERED 3'h6

// Invalid-flag vector positions
`define VX_SNAN 0
`define VX_ISI 1
`define VX_IDI 2
`define VX_ZDZ 3
`define VX_IMZ 4
`define VX_VC 5
`define VX_SOFT 6
`define VX_SQRT 7
`define VX_CVI 8
`define VX_W 9

// Register interface
`define ADDR_CTRL 4'h0
`define ADDR_FLAGS 4'h1
`define ADDR_SUMMARY 4'h2
`define ADDR_PENDING 4'h3

// Result constants
`define QNAN_DP 64'h7FF8000000000000
`define INT64_MAX 64'h7FFFFFFFFFFFFFFF
`define INT64_MIN 64'h8000000000000000
`define INT32_MAX 32'h7FFFFFFF
`define INT32_MIN 32'h80000000
`define RESULT_CLASS_FIELD_QNAN 5'h11
`define FP_CONDITION_CODE_UNORD 4'h1

`endif

// ### src/fp_exc_pending.v
// Small pending-invocation tracker holding the faulting instruction tag
`timescale 1ns/1ps
`default_nettype none
module fp_exc_pending #(
	parameter TAG_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Capture and release
	input wire capture,
	input wire [TAG_W-1:0] capture_tag,
	input wire release_now,
	input wire discard,
	// State
	output reg pending_q,
	output reg [TAG_W-1:0] tag_q
);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pending_q <= 1'b0;
			tag_q <= {TAG_W{1'b0}};
		end else begin
			// A new fault keeps the oldest tag so recovery starts at the first culprit
			if (capture && (!pending_q || release_now || discard)) begin
				pending_q <= 1'b1;
				tag_q <= capture_tag;
			end else if (release_now || discard) begin
				pending_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### src/fp_exc_invalid.v
// Floating-point invalid-operation detection, status update and handler invocation
// Operation
// - ignore mode never invokes the handler
// - nonrecoverable mode may invoke late
// - recoverable mode late, faulting tag supplied, younger held
// - precise mode invokes at faulting instruction
// - status instruction flushes pending imprecise invocations
// - result writes depend only on enables
// - first enabled fault or software request with nonzero mode traps
// - signaling NaN flags except move-type ops
// - inf-inf, inf/inf, 0/0, inf*0 flag separately
// - ordered compare with NaN flags compare
// - invalid compare keeps flags, sets unordered
// - negative nonzero root sets root flag
// - oversize, infinite or NaN convert flags
// - software request flag raises invalid exception
// - software request keeps written round/class fields
// - one or two flags set regardless
// - enabled: target, class unchanged, summary set
// - disabled arithmetic writes quiet NaN, class
// - positive invalid convert64 saturates most positive
// - negative/NaN invalid convert64 saturates most negative
// - convert32 saturates low word by sign
// - sticky summary set on new flag
// - enabled summary follows flags and enables
`include "fp_exc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fp_exc_invalid #(
	parameter TAG_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Machine state mode bits
	input wire fp_exc_mode_hi,
	input wire fp_exc_mode_lo,
	// Instruction from the execution pipeline
	input wire op_valid,
	input wire [2:0] op_class,
	input wire [TAG_W-1:0] op_tag,
	input wire op_is_add_sub,
	input wire op_is_div,
	input wire op_is_mul,
	input wire op_is_root,
	input wire op_status_instr,
	input wire a_snan,
	input wire b_snan,
	input wire c_snan,
	input wire a_nan,
	input wire b_nan,
	input wire a_inf,
	input wire b_inf,
	input wire c_inf,
	input wire a_zero,
	input wire b_zero,
	input wire c_zero,
	input wire a_neg,
	input wire eff_sub,
	input wire cvt_too_big,
	// Software write of status fields
	input wire sw_write,
	input wire [`VX_W-1:0] sw_flags,
	input wire sw_round_up,
	input wire sw_inexact,
	input wire [4:0] sw_class,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	// Result to target register
	output reg result_write_q,
	output reg [63:0] result_data_q,
	output reg result_upper_only_q,
	// Status fields
	output reg [`VX_W-1:0] vx_flags_q,
	output reg exception_summary_sticky_q,
	output reg enabled_exception_summary_q,
	output reg round_up_flag_q,
	output reg round_inexact_flag_q,
	output reg [4:0] result_class_field_q,
	output reg [3:0] fp_condition_code_q,
	// Exception sequencer
	output wire hold_younger,
	output reg handler_invoke_q,
	output reg [TAG_W-1:0] fault_tag_q
);
	reg invalid_op_enable_q;
	reg [`VX_W-1:0] det;
	reg [`VX_W-1:0] flags_d;
	reg sticky_d;
	reg fex_d;
	reg raise;
	wire [1:0] mode = {fp_exc_mode_hi, fp_exc_mode_lo};
	// Decoded modes keep the invocation logic readable
	wire mode_ignore = (mode == `MODE_IGNORE);
	wire mode_nonrec = (mode == `MODE_IMP_NONREC);
	wire mode_rec = (mode == `MODE_IMP_REC);
	wire mode_precise = (mode == `MODE_PRECISE);
	wire imprecise = mode_nonrec || mode_rec;

	wire pending_q;
	wire [TAG_W-1:0] pend_tag_q;
	wire move_like = (op_class == `OP_MOVE);
	wire any_nan = a_nan | b_nan;
	wire any_snan = a_snan | b_snan | c_snan;
	wire ctl_wr = reg_wr && (reg_addr == `ADDR_CTRL);
	wire flag_wr = reg_wr && (reg_addr == `ADDR_FLAGS);

	// Individual conditions; op_valid qualifies them in the detector
	wire cond_snan = any_snan && !move_like;
	wire cond_isi = op_is_add_sub && a_inf && b_inf && eff_sub;
	wire cond_idi = op_is_div && a_inf && b_inf;
	wire cond_zdz = op_is_div && a_zero && b_zero;
	wire cond_imz = op_is_mul && ((a_inf && c_zero) || (a_zero && c_inf));
	wire cond_vc = (op_class == `OP_CMP_ORDERED) && any_nan;
	// A NaN operand is excluded whatever its sign, so a NaN root only raises the signaling flag
	wire cond_sqrt = op_is_root && a_neg && !a_zero && !a_nan;
	wire cond_cvi = ((op_class == `OP_CVT64) || (op_class == `OP_CVT32)) &&
		(cvt_too_big || a_inf || a_nan);

	// Detection of invalid conditions
	always @* begin
		det = {`VX_W{1'b0}};
		if (op_valid) begin
			det[`VX_SNAN] = cond_snan;
			det[`VX_ISI] = cond_isi;
			det[`VX_IDI] = cond_idi;
			det[`VX_ZDZ] = cond_zdz;
			det[`VX_IMZ] = cond_imz;
			det[`VX_VC] = cond_vc;
			det[`VX_SQRT] = cond_sqrt;
			det[`VX_CVI] = cond_cvi;
		end
	end

	// Any detected condition is an invalid operation
	wire invalid = |det;
	// Software may also raise the request through the flags register
	wire [`VX_W-1:0] sw_set = (sw_write ? sw_flags : {`VX_W{1'b0}}) |
		(flag_wr ? reg_wdata[`VX_W-1:0] : {`VX_W{1'b0}});
	wire soft_new = sw_set[`VX_SOFT] && !vx_flags_q[`VX_SOFT];
	// Compares and converts take their own status actions
	wire cvt = (op_class == `OP_CVT64) || (op_class == `OP_CVT32);
	wire cmp = (op_class == `OP_CMP_ORDERED) || (op_class == `OP_CMP_UNORDERED);

	// Saturation follows the operand sign; a NaN counts as negative
	wire cvt_neg = a_neg || a_nan;

	// Each condition bit is sticky: once set, only reset clears it
	wire [`VX_W-1:0] flag_next;
	genvar gi;
	generate
		for (gi = 0; gi < `VX_W; gi = gi + 1) begin : g_flag
			assign flag_next[gi] = vx_flags_q[gi] | det[gi] | sw_set[gi];
		end
	endgenerate
	// Bits raised this cycle, for the sticky summary
	wire [`VX_W-1:0] flag_rise = flag_next & ~vx_flags_q;
	// An enabled invalid operation or a fresh software request sets the enabled summary
	wire trap_cause = invalid || soft_new;

	// Status field next state
	always @* begin
		flags_d = flag_next;
		sticky_d = exception_summary_sticky_q;
		// A software write that sets a bit counts even when the bit was already set
		if ((|flag_rise) || (|sw_set)) begin
			sticky_d = 1'b1;
		end
		fex_d = enabled_exception_summary_q;
		// Only the invalid enable is modelled; summary follows its flags
		if (invalid_op_enable_q && (|flags_d)) begin
			fex_d = 1'b1;
		end
		// Only the first enabled fault traps; later ones wait for a summary clear
		raise = invalid_op_enable_q && trap_cause && !enabled_exception_summary_q;
		if (ctl_wr) begin
			// A clear by software loses to an enabled fault in the same cycle
			fex_d = reg_wdata[2] | (invalid_op_enable_q && trap_cause);
		end
	end

	// Condition bits and the two summaries
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vx_flags_q <= {`VX_W{1'b0}};
			exception_summary_sticky_q <= 1'b0;
			enabled_exception_summary_q <= 1'b0;
			invalid_op_enable_q <= 1'b0;
		end else begin
			vx_flags_q <= flags_d;
			exception_summary_sticky_q <= sticky_d;
			enabled_exception_summary_q <= fex_d;
			if (ctl_wr) begin
				invalid_op_enable_q <= reg_wdata[0];
			end
		end
	end

	// Rounding flags and result class
	// A software write wins over a same-cycle instruction so the request keeps its fields
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			round_up_flag_q <= 1'b0;
			round_inexact_flag_q <= 1'b0;
			result_class_field_q <= 5'h00;
		end else if (sw_write) begin
			round_up_flag_q <= sw_round_up;
			round_inexact_flag_q <= sw_inexact;
			result_class_field_q <= sw_class;
		end else if (invalid && !cmp) begin
			round_up_flag_q <= 1'b0;
			round_inexact_flag_q <= 1'b0;
			// Enabled keeps the class; converts leave it undefined, so it is kept too
			if (!invalid_op_enable_q && !cvt) begin
				result_class_field_q <= `RESULT_CLASS_FIELD_QNAN;
			end
		end
	end

	// Condition code; compares leave the rounding flags and class alone
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fp_condition_code_q <= 4'h0;
		end else if (invalid && cmp && !sw_write) begin
			fp_condition_code_q <= `FP_CONDITION_CODE_UNORD;
		end
	end

	// Result delivery depends on the enable alone, never on the mode
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			result_write_q <= 1'b0;
			result_data_q <= 64'h0000000000000000;
			result_upper_only_q <= 1'b0;
		end else begin
			result_write_q <= 1'b0;
			result_upper_only_q <= 1'b0;
			// Write pulse lasts one cycle; the data hold until the next write
			if (invalid && !invalid_op_enable_q && !cmp) begin
				result_write_q <= 1'b1;
				if (op_class == `OP_CVT64) begin
					if (cvt_neg) begin
						result_data_q <= `INT64_MIN;
					end else begin
						result_data_q <= `INT64_MAX;
					end
				end else if (op_class == `OP_CVT32) begin
					// High word left undefined; zero is the cheapest choice
					result_upper_only_q <= 1'b1;
					if (cvt_neg) begin
						result_data_q <= {32'h00000000, `INT32_MIN};
					end else begin
						result_data_q <= {32'h00000000, `INT32_MAX};
					end
				end else begin
					result_data_q <= `QNAN_DP;
				end
			end
		end
	end

	// Handler invocation by mode
	wire precise_trap = raise && mode_precise;
	// A status-register instruction forces a pending imprecise entry out now
	wire flush = op_valid && op_status_instr && imprecise;
	wire cap = raise && imprecise;
	// A pending fault is handed over exactly once, the cycle after capture or on a
	// flush; a switch to ignore mode drops it without an entry
	wire deliver = pending_q && !mode_ignore && !precise_trap;

	fp_exc_pending #(
		.TAG_W(TAG_W)
	) u_pending (
		.ref_clk(ref_clk),
		.rst(rst),
		.capture(cap),
		.capture_tag(op_tag),
		.release_now(deliver || flush),
		.discard(mode_ignore),
		.pending_q(pending_q),
		.tag_q(pend_tag_q)
	);

	// Younger instructions wait on a recoverable pending fault
	assign hold_younger = pending_q && mode_rec;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			handler_invoke_q <= 1'b0;
			fault_tag_q <= {TAG_W{1'b0}};
		end else begin
			handler_invoke_q <= 1'b0;
			if (mode == `MODE_IGNORE) begin
				handler_invoke_q <= 1'b0;
			end else if (precise_trap) begin
				handler_invoke_q <= 1'b1;
				fault_tag_q <= op_tag;
			end else if (deliver) begin
				// The tag lets recoverable-mode software find and redo the culprit
				handler_invoke_q <= 1'b1;
				fault_tag_q <= pend_tag_q;
			end
		end
	end

	// Register reads
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 32'h00000000;
		end else begin
			// Zero outside the read cycle so a stale value never looks fresh
			reg_rdata_q <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					`ADDR_CTRL: begin
						reg_rdata_q <= {29'h0, enabled_exception_summary_q, mode_ignore,
							invalid_op_enable_q};
					end
					`ADDR_FLAGS: begin
						reg_rdata_q <= {23'h0, vx_flags_q};
					end
					`ADDR_SUMMARY: begin
						reg_rdata_q <= {30'h0, enabled_exception_summary_q,
							exception_summary_sticky_q};
					end
					// The pending tag only fits while TAG_W stays below 32
					`ADDR_PENDING: begin
						reg_rdata_q <= {{(31-TAG_W){1'b0}}, pend_tag_q, pending_q};
					end
					default: begin
						reg_rdata_q <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### test/fp_exc_invalid_properties.sv
// Concurrent checks on the ports of the invalid-operation exception unit
`include "fp_exc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fp_exc_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Inputs
	input wire logic fp_exc_mode_hi,
	input wire logic fp_exc_mode_lo,
	input wire logic op_valid,
	input wire logic [2:0] op_class,
	input wire logic a_snan,
	input wire logic a_nan,
	// Outputs
	input wire logic result_write_q,
	input wire logic [`VX_W-1:0] vx_flags_q,
	input wire logic exception_summary_sticky_q,
	input wire logic enabled_exception_summary_q,
	input wire logic round_up_flag_q,
	input wire logic [4:0] result_class_field_q,
	input wire logic [3:0] fp_condition_code_q,
	input wire logic hold_younger,
	input wire logic handler_invoke_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire [1:0] mode = {fp_exc_mode_hi, fp_exc_mode_lo};
	a_ignore_quiet: assert property ((mode == 2'h0) [*3] |-> !handler_invoke_q)
		else $error("handler entered in ignore mode");
	a_precise_entry: assert property ($rose(enabled_exception_summary_q) && mode == 2'h3 |-> handler_invoke_q)
		else $error("precise entry missing");
	a_imprecise_late: assert property ($rose(enabled_exception_summary_q) && mode[0] != mode[1] |-> !handler_invoke_q ##1 handler_invoke_q)
		else $error("imprecise entry not one cycle late");
	a_hold_recov: assert property ($rose(enabled_exception_summary_q) && mode == 2'h2 |-> hold_younger)
		else $error("younger work not held");
	a_snan_flag: assert property (op_valid && a_snan && op_class != `OP_MOVE |=> vx_flags_q[`VX_SNAN])
		else $error("signaling flag missing");
	a_sticky_sum: assert property (|(vx_flags_q & ~$past(vx_flags_q)) |-> exception_summary_sticky_q)
		else $error("sticky summary missing");
	a_enabled_nowrite: assert property ($rose(enabled_exception_summary_q) |-> !result_write_q)
		else $error("target written while enabled");
	a_cmp_unord: assert property (op_valid && op_class == `OP_CMP_ORDERED && a_nan |=> vx_flags_q[`VX_VC] && fp_condition_code_q == `FP_CONDITION_CODE_UNORD && $stable(round_up_flag_q) && $stable(result_class_field_q))
		else $error("compare handling wrong");
	c_precise: cover property (handler_invoke_q && mode == 2'h3);
	c_recov: cover property (hold_younger);
	c_write: cover property (result_write_q);
endmodule
bind fp_exc_invalid fp_exc_props chk (.*);
`default_nettype wire

// ### test/fp_seq_model.sv
// Exception sequencer stand-in that counts handler entries and stalls
`timescale 1ns/1ps
`default_nettype none
module fp_seq_model (
	// Clock
	input wire logic ref_clk,
	// From the exception unit
	input wire logic handler_invoke_q,
	input wire logic hold_younger,
	// Counts kept across resets
	output var int entries,
	output var int stalls
);
	// Younger issue waits while a recoverable fault is outstanding
	always @(posedge ref_clk) begin
		if (handler_invoke_q === 1'b1) entries <= entries + 1;
		if (hold_younger === 1'b1) stalls <= stalls + 1;
	end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the invalid-operation exception unit
`include "fp_exc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk, rst, fp_exc_mode_hi, fp_exc_mode_lo, op_valid, sw_write, sw_round_up;
	logic sw_inexact, reg_wr, reg_rd;
	wire op_is_add_sub, op_is_div, op_is_mul, op_is_root, op_status_instr, a_snan, b_snan;
	wire c_snan, a_nan, b_nan, a_inf, b_inf, c_inf, a_zero, b_zero, c_zero, a_neg, eff_sub;
	wire cvt_too_big, result_write_q, result_upper_only_q, exception_summary_sticky_q;
	wire enabled_exception_summary_q, round_up_flag_q, round_inexact_flag_q;
	wire hold_younger, handler_invoke_q;
	logic [2:0] op_class;
	logic [7:0] op_tag;
	logic [18:0] q;
	logic [8:0] sw_flags;
	logic [4:0] sw_class;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	wire [31:0] reg_rdata_q;
	wire [63:0] result_data_q;
	wire [8:0] vx_flags_q;
	wire [7:0] fault_tag_q;
	wire [4:0] result_class_field_q;
	wire [3:0] fp_condition_code_q;
	int errors, n_compared, entries, stalls;
	logic [63:0] rq[$], tq[$];
	logic [18:0] tv[6] = '{19'h40182, 19'h20180, 19'h20030, 19'h10108, 19'h08004, 19'h02000};
	int fb[6] = '{1, 2, 3, 4, 7, 0};
	assign {op_is_add_sub, op_is_div, op_is_mul, op_is_root, op_status_instr, a_snan, b_snan,
		c_snan, a_nan, b_nan, a_inf, b_inf, c_inf, a_zero, b_zero, c_zero, a_neg, eff_sub,
		cvt_too_big} = q;
	fp_exc_invalid #(.TAG_W(8)) uut (.*);
	fp_seq_model seq (.*);
	always #50 ref_clk = ~ref_clk;
	task check(input string n, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task final_report;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task rg(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
		if (!w) check("rdata", d, reg_rdata_q);
	endtask
	// Kind 1 expects a target write, kind 2 a handler entry
	task op(input logic [2:0] c, input logic [18:0] v, input logic [63:0] e, input int k);
		@(posedge ref_clk);
		op_valid <= 1;
		op_class <= c;
		q <= v;
		op_tag <= 8'($urandom);
		@(posedge ref_clk);
		op_valid <= 0;
		q <= 19'($urandom);
		if (k == 1) rq.push_back(e);
		if (k == 2) tq.push_back(op_tag);
		tick(3);
	endtask
	task reset(input logic [1:0] m);
		@(posedge ref_clk);
		rst <= 1;
		{fp_exc_mode_hi, fp_exc_mode_lo} <= m;
		tick(2);
		rst <= 0;
	endtask
	always @(posedge ref_clk) begin
		#1;
		if (result_write_q === 1'b1) begin
			if (rq.size() == 0) check("write", 0, 1);
			else check("result", rq.pop_front(), result_upper_only_q ? {32'h0, result_data_q[31:0]} : result_data_q);
		end
		if (handler_invoke_q === 1'b1) begin
			if (tq.size() == 0) check("invoke", 0, 1);
			else check("tag", tq.pop_front(), fault_tag_q);
		end
	end
	initial begin
		{ref_clk, op_valid, sw_write, sw_round_up, sw_inexact, reg_wr, reg_rd} = 0;
		rst = 1;
		{fp_exc_mode_hi, fp_exc_mode_lo, op_class, op_tag, q, sw_flags, sw_class, reg_addr} = 0;
		reg_wdata = 0;
		void'($urandom(32'hD30BDD98));
		tick(12);
		// Ignore mode with the enable set is visited last as a corner
		for (int m = 3; m >= 0; m--) begin
			reset(2'(m));
			rg(1, `ADDR_CTRL, 32'h1);
			op(`OP_ARITH, 19'h02000, 0, m > 0 ? 2 : 0);
			check("fex", 1, enabled_exception_summary_q);
		end
		reset(2'h0);
		op(`OP_MOVE, 19'h02000, 0, 0);
		check("flags", 0, vx_flags_q);
		op(`OP_CMP_ORDERED, 19'h00400, 0, 0);
		check("cc", `FP_CONDITION_CODE_UNORD, fp_condition_code_q);
		check("flags", 9'h020, vx_flags_q);
		for (int i = 0; i < 6; i++) begin
			op(`OP_ARITH, tv[i], `QNAN_DP, 1);
			check("flag", 1, vx_flags_q[fb[i]]);
		end
		check("class", `RESULT_CLASS_FIELD_QNAN, result_class_field_q);
		check("round", 0, {round_up_flag_q, round_inexact_flag_q});
		op(`OP_CVT64, 19'h00001, `INT64_MAX, 1);
		op(`OP_CVT64, 19'h00005, `INT64_MIN, 1);
		op(`OP_CVT64, 19'h00400, `INT64_MIN, 1);
		op(`OP_CVT32, 19'h00005, {32'h0, `INT32_MIN}, 1);
		op(`OP_CVT32, 19'h00100, {32'h0, `INT32_MAX}, 1);
		rg(0, `ADDR_FLAGS, 32'h1BF);
		rg(0, `ADDR_SUMMARY, 32'h1);
		rg(0, 4'hF, 0);
		@(posedge ref_clk);
		sw_write <= 1;
		sw_flags <= 9'h040;
		sw_round_up <= 1;
		sw_class <= 5'h0A;
		@(posedge ref_clk);
		sw_write <= 0;
		tick(2);
		check("soft", 9'h1FF, vx_flags_q);
		check("fr", 1, round_up_flag_q);
		check("class", 5'h0A, result_class_field_q);
		check("entries", 3, entries);
		check("stalls", 1, stalls > 0);
		check("left", 0, rq.size() + tq.size());
		final_report;
	end
	initial begin
		#(100 * 5000);
		errors++;
		final_report;
	end
endmodule
`default_nettype wire
